// File: ctrl_status_regs.sv
// control and status register bank of the slave board
`timescale 1ns/1ps

module ctrl_status_regs
  import ctrl_status_pkg::*;
#(
  parameter bit HAS_AUX_CONNECTOR = 1'b1,
  // arbitrary neutral revision value
  parameter logic [15:0] FIRMWARE_REVISION = 16'h0200
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register access port, one-cycle request strobe
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic iack_i,
  output logic [15:0] rdata_o,
  output logic ack_o,
  // extra reset sources from the board
  input wire logic soft_reset_req_i,
  // pins: slot sense lines and control bus lines
  input wire logic [SLOT_W-1:0] slot_sense_lines_i,
  input wire pin_status_t pins_i,
  // same-clock status from the readout logic
  input wire local_status_t local_i,
  input wire logic bus_error_event_i,
  // configuration space address bits A23..A19 of the current cycle
  input wire logic [SLOT_W-1:0] csr_addr_i,
  // settings towards the rest of the board
  output logic [SLOT_W-1:0] slot_position_o,
  output logic csr_match_o,
  output logic geo_addressing_enable_o,
  output logic [CHAIN_ADDR_W-1:0] chain_address_o,
  output logic select_address_o,
  output logic module_reset_o,
  output logic [IRQ_LEVEL_W-1:0] irq_level_o,
  output logic irq_enable_o,
  output logic [IRQ_VECTOR_W-1:0] irq_vector_o
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  initial begin
    if (SLOT_W != 5) begin
      $error("slot field must be five bits");
    end
  end

  // ---------------------------------------------------------------
  // state and decode helpers
  // ---------------------------------------------------------------
  bank_state_t st;
  bank_state_t next_st;
  logic soft_reset;
  logic busy;
  logic slot_unknown;
  logic [15:0] control_word;
  logic [15:0] status_word;

  // a reset from software: the persistent bit or a one-shot request
  assign soft_reset = st.persistent_reset | soft_reset_req_i;

  // busy also covers the slot reload cycle after any reset
  assign busy = local_i.conversion_busy | soft_reset | st.slot_reload
    | local_i.buffer_full | local_i.memory_test;

  // no aux connector means nothing was ever sensed
  assign slot_unknown = !HAS_AUX_CONNECTOR;

  // control word view, meaningless bits zero
  always_comb begin
    control_word = 16'h0000;
    control_word[CTRL_BUS_ERROR_FLAG] = st.bus_error_flag;
    control_word[CTRL_SELECT_ADDRESS] = st.select_address;
    control_word[CTRL_PERSISTENT_RESET] = st.persistent_reset;
  end

  // status word view
  always_comb begin
    status_word = 16'h0000;
    status_word[ST_EVENT_AVAILABLE] = local_i.event_available;
    status_word[ST_CHAIN_EVENT_AVAILABLE] = st.pins_sync.chain_ready;
    status_word[ST_BUSY] = busy;
    status_word[ST_CHAIN_BUSY] = st.pins_sync.chain_busy;
    status_word[ST_SLOT_UNKNOWN] = slot_unknown;
    status_word[ST_READOUT_DONE] = local_i.readout_done;
    status_word[ST_TERM_ALL_ON] = st.pins_sync.term_all_on;
    status_word[ST_TERM_ALL_OFF] = st.pins_sync.term_all_off;
    status_word[ST_EVENT_THRESHOLD_REACHED] = local_i.event_threshold_reached;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;

    // two-flop synchronisers for everything arriving on pins
    next_st.sense_meta = slot_sense_lines_i;
    next_st.sense_sync = st.sense_meta;
    next_st.pins_meta = pins_i;
    next_st.pins_sync = st.pins_meta;

    // a pending reload picks its source once the reset has gone
    if (st.slot_reload && !soft_reset) begin
      next_st.slot_reload = 1'b0;
      if (HAS_AUX_CONNECTOR) begin
        next_st.slot_active = st.sense_sync;
      end else begin
        next_st.slot_active = st.slot_written;
      end
    end

    // register writes and reads
    if (req_i && req_write_i) begin
      if (req_addr_i == OFS_SLOT_ADDRESS) begin
        // with aux lines the write is left to time out on the bus
        if (!HAS_AUX_CONNECTOR) begin
          next_st.slot_written = req_wdata_i[SLOT_W-1:0];
          next_st.ack = 1'b1;
        end
      end else if (req_addr_i == OFS_BROADCAST_CHAIN_ADDRESS) begin
        next_st.chain_address = req_wdata_i[CHAIN_ADDR_W-1:0];
        next_st.ack = 1'b1;
      end else if (req_addr_i == OFS_CONTROL_BITS_SET) begin
        if (req_wdata_i[CTRL_BUS_ERROR_FLAG]) begin
          next_st.bus_error_flag = 1'b1;
        end
        if (req_wdata_i[CTRL_SELECT_ADDRESS]) begin
          next_st.select_address = 1'b1;
        end
        if (req_wdata_i[CTRL_PERSISTENT_RESET]) begin
          next_st.persistent_reset = 1'b1;
        end
        next_st.ack = 1'b1;
      end else if (req_addr_i == OFS_CONTROL_BITS_CLEAR) begin
        if (req_wdata_i[CTRL_BUS_ERROR_FLAG]) begin
          next_st.bus_error_flag = 1'b0;
        end
        if (req_wdata_i[CTRL_SELECT_ADDRESS]) begin
          next_st.select_address = 1'b0;
        end
        if (req_wdata_i[CTRL_PERSISTENT_RESET]) begin
          next_st.persistent_reset = 1'b0;
        end
        next_st.ack = 1'b1;
      end else if (req_addr_i == OFS_INTERRUPT_LEVEL) begin
        next_st.irq_level = req_wdata_i[IRQ_LEVEL_W-1:0];
        next_st.ack = 1'b1;
      end else if (req_addr_i == OFS_INTERRUPT_VECTOR) begin
        next_st.irq_vector = req_wdata_i[IRQ_VECTOR_W-1:0];
        next_st.ack = 1'b1;
      end else if (req_addr_i == OFS_FIRMWARE_REVISION
                   || req_addr_i == OFS_MODULE_STATUS_PRIMARY) begin
        // read-only words accept and drop the write
        next_st.ack = 1'b1;
      end
    end else if (req_i) begin
      next_st.ack = 1'b1;
      if (req_addr_i == OFS_FIRMWARE_REVISION) begin
        next_st.rdata = FIRMWARE_REVISION;
      end else if (req_addr_i == OFS_SLOT_ADDRESS) begin
        next_st.rdata = {11'h000, st.slot_active};
      end else if (req_addr_i == OFS_BROADCAST_CHAIN_ADDRESS) begin
        next_st.rdata = {8'h00, st.chain_address};
      end else if (req_addr_i == OFS_CONTROL_BITS_SET
                   || req_addr_i == OFS_CONTROL_BITS_CLEAR) begin
        next_st.rdata = control_word;
      end else if (req_addr_i == OFS_INTERRUPT_LEVEL) begin
        next_st.rdata = {13'h0000, st.irq_level};
      end else if (req_addr_i == OFS_INTERRUPT_VECTOR) begin
        next_st.rdata = {8'h00, st.irq_vector};
      end else if (req_addr_i == OFS_MODULE_STATUS_PRIMARY) begin
        next_st.rdata = status_word;
      end else begin
        // unmapped: no acknowledge, the master times out
        next_st.ack = 1'b0;
      end
    end else if (iack_i && st.irq_level != RST_IRQ_LEVEL) begin
      // only an interrupter with a level set answers the acknowledge
      next_st.rdata = {8'h00, st.irq_vector};
      next_st.ack = 1'b1;
    end

    // a hardware bus error event wins over a software clear
    if (bus_error_event_i) begin
      next_st.bus_error_flag = 1'b1;
    end

    // software reset clears only the bus error flag and rearms the reload
    if (soft_reset) begin
      next_st.bus_error_flag = 1'b0;
      next_st.slot_reload = 1'b1;
    end

    // region decode against the active slot, only when sensing exists
    next_st.csr_match = HAS_AUX_CONNECTOR
      && (csr_addr_i == st.slot_active);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // hardware reset loads the reset image of the bank; pin synchronisers keep sampling during reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      next_st_reset();
    end else begin
      st <= next_st;
    end
  end

  // reset image of the bank; synchronisers keep sampling so the reload sees the real slot
  task automatic next_st_reset();
    st.sense_meta <= slot_sense_lines_i;
    st.sense_sync <= st.sense_meta;
    st.pins_meta <= pins_i;
    st.pins_sync <= st.pins_meta;
    st.slot_written <= RST_SLOT_ADDRESS;
    st.slot_active <= RST_SLOT_ADDRESS;
    st.slot_reload <= 1'b1;
    st.chain_address <= RST_CHAIN_ADDRESS;
    st.bus_error_flag <= 1'b0;
    st.select_address <= 1'b0;
    st.persistent_reset <= 1'b0;
    st.irq_level <= RST_IRQ_LEVEL;
    st.irq_vector <= RST_IRQ_VECTOR;
    st.rdata <= 16'h0000;
    st.ack <= 1'b0;
    st.csr_match <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // outputs from flip-flops of the bank, except geo_addressing_enable_o (parameter) and irq_enable_o (decoded level)
  // ---------------------------------------------------------------
  assign rdata_o = st.rdata;
  assign ack_o = st.ack;
  assign slot_position_o = st.slot_active;
  assign csr_match_o = st.csr_match;
  assign geo_addressing_enable_o = HAS_AUX_CONNECTOR;
  assign chain_address_o = st.chain_address;
  assign select_address_o = st.select_address;
  assign module_reset_o = st.persistent_reset;
  assign irq_level_o = st.irq_level;
  assign irq_enable_o = (st.irq_level != RST_IRQ_LEVEL);
  assign irq_vector_o = st.irq_vector;

endmodule

// File: ctrl_status_pkg.sv
// constants and types shared by the control and status register bank
package ctrl_status_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses within the board window)
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_FIRMWARE_REVISION = 16'h1000;
  localparam logic [15:0] OFS_SLOT_ADDRESS = 16'h1002;
  localparam logic [15:0] OFS_BROADCAST_CHAIN_ADDRESS = 16'h1004;
  localparam logic [15:0] OFS_CONTROL_BITS_SET = 16'h1006;
  localparam logic [15:0] OFS_CONTROL_BITS_CLEAR = 16'h1008;
  localparam logic [15:0] OFS_INTERRUPT_LEVEL = 16'h100A;
  localparam logic [15:0] OFS_INTERRUPT_VECTOR = 16'h100C;
  localparam logic [15:0] OFS_MODULE_STATUS_PRIMARY = 16'h100E;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int SLOT_W = 5;
  localparam int CHAIN_ADDR_W = 8;
  localparam int IRQ_LEVEL_W = 3;
  localparam int IRQ_VECTOR_W = 8;
  localparam int CTRL_BUS_ERROR_FLAG = 3;
  localparam int CTRL_SELECT_ADDRESS = 4;
  localparam int CTRL_PERSISTENT_RESET = 7;
  localparam int ST_EVENT_AVAILABLE = 0;
  localparam int ST_CHAIN_EVENT_AVAILABLE = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_CHAIN_BUSY = 3;
  localparam int ST_SLOT_UNKNOWN = 4;
  localparam int ST_READOUT_DONE = 5;
  localparam int ST_TERM_ALL_ON = 6;
  localparam int ST_TERM_ALL_OFF = 7;
  localparam int ST_EVENT_THRESHOLD_REACHED = 8;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [SLOT_W-1:0] RST_SLOT_ADDRESS = 5'h1F;
  localparam logic [CHAIN_ADDR_W-1:0] RST_CHAIN_ADDRESS = 8'hAA;
  localparam logic [IRQ_LEVEL_W-1:0] RST_IRQ_LEVEL = 3'h0;
  localparam logic [IRQ_VECTOR_W-1:0] RST_IRQ_VECTOR = 8'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // status inputs produced by logic on the same clock
  typedef struct packed {
    logic event_available;
    logic conversion_busy;
    logic buffer_full;
    logic memory_test;
    logic readout_done;
    logic event_threshold_reached;
  } local_status_t;

  // status inputs arriving on pins, synchronised before use
  typedef struct packed {
    logic chain_ready;
    logic chain_busy;
    logic term_all_on;
    logic term_all_off;
  } pin_status_t;

  // whole state of the register bank
  typedef struct packed {
    logic [SLOT_W-1:0] sense_meta;
    logic [SLOT_W-1:0] sense_sync;
    pin_status_t pins_meta;
    pin_status_t pins_sync;
    logic [SLOT_W-1:0] slot_written;
    logic [SLOT_W-1:0] slot_active;
    logic slot_reload;
    logic [CHAIN_ADDR_W-1:0] chain_address;
    logic bus_error_flag;
    logic select_address;
    logic persistent_reset;
    logic [IRQ_LEVEL_W-1:0] irq_level;
    logic [IRQ_VECTOR_W-1:0] irq_vector;
    logic [15:0] rdata;
    logic ack;
    logic csr_match;
  } bank_state_t;

endpackage

// File: vme_master_model.sv
// bus master model that issues accesses on the register port of the bank
`timescale 1ns/1ps

module vme_master_model (
  // clock
  input wire logic clk_i,
  // answer from the bank
  input wire logic [15:0] rdata_i,
  input wire logic ack_i,
  // request towards the bank
  output logic req_o,
  output logic write_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o,
  output logic iack_o
);
  // idle bus from time zero
  initial begin
    {req_o, iack_o, write_o, addr_o, wdata_o} = '0;
  end

  // one access; released write, address and data lines carry inverted values so stale data never looks valid
  task automatic cycle(input logic ia, input logic w, input logic [15:0] a, input logic [15:0] d,
                       output logic ok, output logic [15:0] q);
    @(negedge clk_i);
    req_o = !ia;
    iack_o = ia;
    write_o = w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    req_o = 1'b0;
    iack_o = 1'b0;
    write_o = !w;
    addr_o = ~a;
    wdata_o = ~d;
    ok = (ack_i === 1'b1);
    q = rdata_i;
  endtask
endmodule

// File: ctrl_status_regs_properties.sv
// concurrent checks on the ports of the control and status register bank
`timescale 1ns/1ps

module ctrl_status_regs_properties
  import ctrl_status_pkg::*;
#(
  parameter bit HAS_AUX_CONNECTOR = 1'b1,
  parameter logic [15:0] FIRMWARE_REVISION = 16'h0200
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // access port
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic iack_i,
  input wire logic [15:0] rdata_o,
  input wire logic ack_o,
  // board side
  input wire logic [SLOT_W-1:0] csr_addr_i,
  input wire logic [SLOT_W-1:0] slot_position_o,
  input wire logic csr_match_o,
  input wire logic select_address_o,
  input wire logic module_reset_o,
  input wire logic [IRQ_LEVEL_W-1:0] irq_level_o,
  input wire logic irq_enable_o,
  input wire logic [IRQ_VECTOR_W-1:0] irq_vector_o
);
  // -------------------------------
  // request and answer shapes
  // -------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_rd(logic [15:0] a);
    req_i && !req_write_i && req_addr_i == a;
  endsequence
  sequence s_wa(logic [15:0] a);
    req_i && req_write_i && req_addr_i == a;
  endsequence
  sequence s_wr(logic [15:0] a, int b);
    s_wa(a) ##0 req_wdata_i[b];
  endsequence
  sequence s_answer(logic [15:0] v);
    ack_o && rdata_o == v;
  endsequence

  // -------------------------------
  // checks
  // -------------------------------
  AST_REVISION: assert property (s_rd(OFS_FIRMWARE_REVISION) |=> s_answer(FIRMWARE_REVISION))
    else $error("revision word wrong");
  AST_SLOT_REFUSED: assert property (s_wa(OFS_SLOT_ADDRESS) ##0 HAS_AUX_CONNECTOR |=> !ack_o)
    else $error("slot write was acknowledged");
  AST_SET: assert property (s_wr(OFS_CONTROL_BITS_SET, CTRL_SELECT_ADDRESS) |=> select_address_o)
    else $error("set write did not set bit");
  AST_CLEAR: assert property (s_wr(OFS_CONTROL_BITS_CLEAR, CTRL_SELECT_ADDRESS) |=> !select_address_o)
    else $error("clear write did not clear bit");
  AST_HOLD: assert property (module_reset_o && !(req_i && req_write_i &&
    req_addr_i == OFS_CONTROL_BITS_CLEAR && req_wdata_i[CTRL_PERSISTENT_RESET]) |=> module_reset_o)
    else $error("persistent reset dropped");
  AST_RELEASE: assert property (s_wr(OFS_CONTROL_BITS_CLEAR, CTRL_PERSISTENT_RESET) |=> !module_reset_o)
    else $error("persistent reset not released");
  AST_IRQ_EN: assert property (irq_enable_o == (irq_level_o != 3'h0))
    else $error("interrupt enable wrong");
  AST_IACK: assert property (iack_i && !req_i && irq_level_o != 3'h0 |=> s_answer({8'h00, irq_vector_o}))
    else $error("vector not returned");
  AST_IACK_OFF: assert property (iack_i && !req_i && irq_level_o == 3'h0 |=> !ack_o)
    else $error("acknowledge with interrupts off");
  AST_BUSY: assert property (s_rd(OFS_MODULE_STATUS_PRIMARY) ##0 module_reset_o |=> ack_o && rdata_o[ST_BUSY])
    else $error("busy clear during reset");
  AST_CSR: assert property (HAS_AUX_CONNECTOR && !module_reset_o |=>
    csr_match_o == $past(csr_addr_i == slot_position_o))
    else $error("slot match wrong");
endmodule

// File: ctrl_status_regs_tb.sv
// self-checking bench for the control and status register bank
`timescale 1ns/1ps

module ctrl_status_regs_tb;
  import ctrl_status_pkg::*;
  localparam logic [15:0] REV = 16'h0200; // arbitrary revision value
  logic clk_i, rst_i, soft_reset_req_i, bus_error_event_i, req, wr, iack, ack, csr_match, sel, mrst;
  logic [15:0] addr, wdata, rdata;
  logic [SLOT_W-1:0] sense, csr_addr, slot;
  pin_status_t pins;
  local_status_t loc;
  int n_fail = 0;
  int checked = 0;

  ctrl_status_regs #(.HAS_AUX_CONNECTOR(1'b1), .FIRMWARE_REVISION(REV)) ctrl_status_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .req_write_i(wr), .req_addr_i(addr), .req_wdata_i(wdata),
    .iack_i(iack), .rdata_o(rdata), .ack_o(ack), .soft_reset_req_i(soft_reset_req_i),
    .slot_sense_lines_i(sense), .pins_i(pins), .local_i(loc), .bus_error_event_i(bus_error_event_i),
    .csr_addr_i(csr_addr), .slot_position_o(slot), .csr_match_o(csr_match), .geo_addressing_enable_o(),
    .chain_address_o(), .select_address_o(sel), .module_reset_o(mrst), .irq_level_o(), .irq_enable_o(),
    .irq_vector_o());
  vme_master_model vme_master_model_i (.clk_i(clk_i), .rdata_i(rdata), .ack_i(ack), .req_o(req),
    .write_o(wr), .addr_o(addr), .wdata_o(wdata), .iack_o(iack));

  // -------------------------------
  // helpers
  // -------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic ia, input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic ok_e, input logic [15:0] q_e);
    logic ok;
    logic [15:0] q;
    vme_master_model_i.cycle(ia, w, a, d, ok, q);
    check($sformatf("ack %h", a), {15'h0000, ok}, {15'h0000, ok_e});
    if (ok_e && !w) begin
      check($sformatf("rdata %h", a), q, q_e);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] q_e);
    acc(1'b0, 1'b0, a, 16'h0000, 1'b1, q_e);
  endtask
  task automatic wt(input logic [15:0] a, input logic [15:0] d);
    acc(1'b0, 1'b1, a, d, 1'b1, 16'h0000);
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // free-running 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // watchdog, far beyond the hundred or so cycles the sequence needs
  initial begin
    #20000;
    n_fail++;
    stop_test;
  end

  // -------------------------------
  // test sequence
  // -------------------------------
  initial begin
    {rst_i, soft_reset_req_i, bus_error_event_i} = 3'b100;
    sense = 5'h0B;
    csr_addr = 5'h00;
    pins = '0;
    loc = '0;
    w(2);
    rst_i = 1'b0;
    w(2);
    rd(16'h1000, REV);
    wt(16'h1000, 16'hFFFF);
    rd(16'h1000, REV);
    acc(1'b0, 1'b1, 16'h1002, 16'h0003, 1'b0, 16'h0000);
    acc(1'b0, 1'b0, 16'h1010, 16'h0000, 1'b0, 16'h0000);
    rd(16'h1004, 16'h00AA);
    wt(16'h1004, 16'h1234);
    rd(16'h1004, 16'h0034);
    rd(16'h100A, 16'h0000);
    rd(16'h100C, 16'h0000);
    acc(1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    wt(16'h100C, 16'h12A5);
    wt(16'h100A, 16'hFFFF);
    rd(16'h100A, 16'h0007);
    acc(1'b1, 1'b0, 16'h0000, 16'h0000, 1'b1, 16'h00A5);
    // control pair, then bus error and software reset on the flag
    rd(16'h1006, 16'h0000);
    wt(16'h1006, 16'h0018);
    rd(16'h1008, 16'h0018);
    check("select", {15'h0000, sel}, 16'h0001);
    wt(16'h1006, 16'h0000);
    wt(16'h1008, 16'h0008);
    rd(16'h1006, 16'h0010);
    bus_error_event_i = 1'b1;
    w(1);
    bus_error_event_i = 1'b0;
    rd(16'h1006, 16'h0018);
    soft_reset_req_i = 1'b1;
    w(1);
    soft_reset_req_i = 1'b0;
    w(2);
    rd(16'h1006, 16'h0010);
    // persistent reset reloads the slot from new sense lines
    sense = 5'h15;
    wt(16'h1006, 16'h0080);
    rd(16'h100E, 16'h0004);
    rd(16'h1006, 16'h0090);
    w(6);
    check("module reset", {15'h0000, mrst}, 16'h0001);
    wt(16'h1008, 16'h0080);
    w(3);
    check("module reset", {15'h0000, mrst}, 16'h0000);
    rd(16'h1002, 16'h0015);
    csr_addr = 5'h15;
    w(2);
    check("csr match", {15'h0000, csr_match}, 16'h0001);
    wt(16'h1008, 16'h0010);
    rd(16'h1006, 16'h0000);
    // status word from local and chain inputs
    loc.event_available = 1'b1;
    loc.readout_done = 1'b1;
    pins.chain_ready = 1'b1;
    pins.chain_busy = 1'b1;
    pins.term_all_on = 1'b1;
    w(3);
    rd(16'h100E, 16'h006B);
    loc.conversion_busy = 1'b1;
    rd(16'h100E, 16'h006F);
    // hardware reset restores defaults and reloads slot
    sense = 5'h0B;
    wt(16'h1006, 16'h0010);
    w(3);
    rst_i = 1'b1;
    w(2);
    rst_i = 1'b0;
    w(2);
    rd(16'h1006, 16'h0000);
    rd(16'h1004, 16'h00AA);
    rd(16'h1002, 16'h000B);
    check("slot", {11'h000, slot}, 16'h000B);
    stop_test;
  end
endmodule

bind ctrl_status_regs ctrl_status_regs_properties #(
  .HAS_AUX_CONNECTOR(HAS_AUX_CONNECTOR),
  .FIRMWARE_REVISION(FIRMWARE_REVISION)
) props_i (
  .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
  .req_wdata_i(req_wdata_i), .iack_i(iack_i), .rdata_o(rdata_o), .ack_o(ack_o), .csr_addr_i(csr_addr_i),
  .slot_position_o(slot_position_o), .csr_match_o(csr_match_o), .select_address_o(select_address_o),
  .module_reset_o(module_reset_o), .irq_level_o(irq_level_o), .irq_enable_o(irq_enable_o),
  .irq_vector_o(irq_vector_o)
);
